//--- hdl/bsd_top.sv
`timescale 1ns/100ps
`include "bsd_regs.svh"

module bsd_top #(
    parameter int ADDR_CYC = `BSD_ADDR_CYC,
    parameter int CMD_CYC  = `BSD_CMD_CYC
) (
    input  wire logic                 clk,            // 100 MHz clock
    input  wire logic                 resetn,         // Async reset, low
    // Processor side
    input  wire logic                 cpu_req,        // Cycle request
    input  wire bsd_pkg::bsd_req_t    cpu_cmd,        // Cycle details
    output logic                      cpu_ready,      // Cycle done pulse
    output logic [15:0]               cpu_rdata,      // Read data
    input  wire logic                 cpu_inta,       // Int ack pulse
    input  wire logic                 cpu_eoi_m,      // EOI master
    input  wire logic                 cpu_eoi_s,      // EOI slave
    output logic                      cpu_intr,       // Interrupt request
    output logic                      cpu_vec_valid,  // Vector valid pulse
    output logic [7:0]                cpu_vector,     // Interrupt vector
    input  wire logic [15:0]          irq_mask,       // Per-input masks
    input  wire logic                 io_expand_en,   // Qualifier option
    // Backplane
    output logic [23:0]               bp_addr,        // Address lines
    output logic                      bp_addr_oe,     // Address drive
    output bsd_pkg::bsd_strb_t        bp_strb,        // Command strobes
    input  wire logic [15:0]          bp_data_in,     // Data from cards
    output logic [15:0]               bp_data_out,    // Data to cards
    output logic                      bp_data_oe,     // Data drive
    input  wire logic                 mem_wide_ack_n, // Memory width ack
    input  wire logic                 io_wide_ack_n,  // I/O width ack
    output logic                      io_expand_qual_n, // Expansion qual
    input  wire logic                 bus_irq_a_n,    // Backplane request
    input  wire logic                 bus_irq_b_n,    // Backplane request
    input  wire logic                 bus_irq_c_n,    // Backplane request
    // Front plane and onboard sources
    input  wire logic [3:0]           fp_irq_n,       // Front-plane reqs
    input  wire logic                 fp_disk_irq_n,  // Disk request
    input  wire logic                 fp_video_irq_n, // Video request
    input  wire bsd_pkg::bsd_onb_irq_t onb_irq        // Onboard, high
);
    // -----------------------------------------------------------
    // Reset release
    // -----------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    // -----------------------------------------------------------
    // Cycle state
    // -----------------------------------------------------------
    bsd_pkg::bsd_state_t state_q;
    bsd_pkg::bsd_state_t state_d;
    bsd_pkg::bsd_req_t   req_q;
    logic [7:0]          cnt_q;
    logic [7:0]          cnt_d;
    logic                lane_q;
    logic                wide_q;
    logic [15:0]         rdata_q;
    logic                ready_q;

    logic                wide_ack;
    logic                split;
    logic                last_cmd;
    logic                last_addr;
    logic [23:0]         cyc_addr;
    logic [23:0]         dec_addr;
    logic                exp_hit;
    logic                hi_lane;
    logic                in_cmd;

    // Sample the line that matches the cycle type
    assign wide_ack  = req_q.is_io ? !io_wide_ack_n : !mem_wide_ack_n;
    // A word needs two cycles only when the card answered narrow
    assign split     = req_q.word && !wide_q;
    assign last_addr = cnt_q == 8'(ADDR_CYC - 1);
    assign last_cmd  = cnt_q == 8'(CMD_CYC - 1);
    // Second half of a split goes to the odd byte address
    assign cyc_addr  = {req_q.addr[23:1], req_q.addr[0] | lane_q};
    // Odd byte to a wide card rides the high lane
    assign hi_lane   = wide_q && !req_q.word && req_q.addr[0];
    assign in_cmd    = state_q == bsd_pkg::ST_CMD;

    bsd_io_decode u_dec (
        .cpu_addr (cyc_addr),
        .is_io    (req_q.is_io),
        .exp_en   (io_expand_en),
        .bp_addr  (dec_addr),
        .exp_hit  (exp_hit)
    );

    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q + 8'h01;
        case (state_q)
            bsd_pkg::ST_IDLE:
            begin
                cnt_d = 8'h00;
                // Acknowledge cycles never start a backplane cycle
                if (cpu_req && !cpu_inta)
                    state_d = bsd_pkg::ST_ADDR;
            end
            bsd_pkg::ST_ADDR:
                if (last_addr)
                begin
                    cnt_d   = 8'h00;
                    state_d = bsd_pkg::ST_CMD;
                end
            bsd_pkg::ST_CMD:
                if (last_cmd)
                begin
                    cnt_d   = 8'h00;
                    state_d = (split && !lane_q) ? bsd_pkg::ST_ADDR
                                                 : bsd_pkg::ST_DONE;
                end
            bsd_pkg::ST_DONE:
                state_d = bsd_pkg::ST_IDLE;
            default:
                state_d = bsd_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            state_q <= bsd_pkg::ST_IDLE;
            cnt_q   <= 8'h00;
            req_q   <= '0;
            lane_q  <= 1'b0;
            wide_q  <= 1'b0;
            rdata_q <= 16'h0000;
            ready_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            ready_q <= state_d == bsd_pkg::ST_DONE;
            if (state_q == bsd_pkg::ST_IDLE && state_d == bsd_pkg::ST_ADDR)
            begin
                req_q  <= cpu_cmd;
                lane_q <= 1'b0;
            end
            // Width is judged at the end of address setup
            if (state_q == bsd_pkg::ST_ADDR && last_addr && !lane_q)
                wide_q <= wide_ack;
            if (in_cmd && last_cmd)
            begin
                if (split && !lane_q)
                    lane_q <= 1'b1;
                if (!req_q.wr)
                begin
                    if (wide_q && req_q.word)
                        rdata_q <= bp_data_in;
                    else if (hi_lane)
                        rdata_q <= {8'h00, bp_data_in[15:8]};
                    else if (lane_q)
                        rdata_q[15:8] <= bp_data_in[7:0];
                    else
                        rdata_q <= {8'h00, bp_data_in[7:0]};
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Backplane drive
    // -----------------------------------------------------------
    logic active;

    assign active     = state_q == bsd_pkg::ST_ADDR || in_cmd;
    assign bp_addr_oe = active;
    assign bp_addr    = active ? dec_addr : 24'h000000;
    assign io_expand_qual_n = !(active && exp_hit);
    assign bp_data_oe = active && req_q.wr;
    // Narrow cycles carry each byte on the low lane
    assign bp_data_out = !req_q.wr        ? 16'h0000 :
                         (wide_q && req_q.word) ? req_q.wdata :
                         hi_lane          ? {req_q.wdata[7:0], 8'h00} :
                         lane_q           ? {8'h00, req_q.wdata[15:8]} :
                                            {8'h00, req_q.wdata[7:0]};
    assign bp_strb.mem_rd_n = !(in_cmd && !req_q.is_io && !req_q.wr);
    assign bp_strb.mem_wr_n = !(in_cmd && !req_q.is_io && req_q.wr);
    assign bp_strb.io_rd_n  = !(in_cmd && req_q.is_io && !req_q.wr);
    assign bp_strb.io_wr_n  = !(in_cmd && req_q.is_io && req_q.wr);
    // High lane enabled only for a full word or an odd byte
    assign bp_strb.bhe_n = !(in_cmd && ((wide_q && req_q.word) || hi_lane));

    assign cpu_ready = ready_q;
    assign cpu_rdata = rdata_q;

    // -----------------------------------------------------------
    // Interrupt routing
    // -----------------------------------------------------------
    logic [15:0] irq_in;
    logic [7:0]  m_irq;
    logic        m_int;
    logic [2:0]  m_sel;
    logic [7:0]  m_vec;
    logic        s_int;
    logic [7:0]  s_vec;
    logic        s_ack;
    logic        slave_q;
    logic        vvalid_q;

    assign irq_in[0]  = onb_irq.timer;
    assign irq_in[1]  = onb_irq.kbd;
    assign irq_in[2]  = 1'b0;
    assign irq_in[3]  = !fp_irq_n[0];
    assign irq_in[4]  = !fp_irq_n[1];
    assign irq_in[5]  = !fp_irq_n[2];
    assign irq_in[6]  = onb_irq.floppy;
    assign irq_in[7]  = !fp_irq_n[3];
    assign irq_in[8]  = onb_irq.rtc;
    assign irq_in[`BSD_IRQ_VIDEO] = !fp_video_irq_n;
    assign irq_in[10] = !bus_irq_a_n;
    assign irq_in[11] = !bus_irq_b_n;
    assign irq_in[12] = !bus_irq_c_n;
    assign irq_in[13] = onb_irq.fpu;
    assign irq_in[`BSD_IRQ_DISK] = !fp_disk_irq_n;
    assign irq_in[15] = onb_irq.spare;

    // Slave request enters the master at its cascade input
    assign m_irq = {irq_in[7:3], s_int, irq_in[1:0]};
    assign s_ack = cpu_inta && m_sel == `BSD_CASCADE_IN;

    bsd_pic_bank u_master (
        .clk      (clk),
        .rst_n    (rst_n_q),
        .irq      (m_irq),
        .mask     (irq_mask[7:0]),
        .vec_base (`BSD_MASTER_BASE),
        .ack      (cpu_inta),
        .eoi      (cpu_eoi_m),
        .int_req  (m_int),
        .sel      (m_sel),
        .vector   (m_vec)
    );

    bsd_pic_bank u_slave (
        .clk      (clk),
        .rst_n    (rst_n_q),
        .irq      (irq_in[15:8]),
        .mask     (irq_mask[15:8]),
        .vec_base (`BSD_SLAVE_BASE),
        .ack      (s_ack),
        .eoi      (cpu_eoi_s),
        .int_req  (s_int),
        .sel      (),
        .vector   (s_vec)
    );

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            slave_q  <= 1'b0;
            vvalid_q <= 1'b0;
        end
        else
        begin
            vvalid_q <= cpu_inta;
            if (cpu_inta)
                slave_q <= s_ack;
        end
    end

    assign cpu_intr      = m_int;
    assign cpu_vec_valid = vvalid_q;
    // Vector comes from the onboard banks only
    assign cpu_vector    = slave_q ? s_vec : m_vec;
endmodule

//--- common/bsd_regs.svh
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH

// ---------------------------------------------------------------
// Backplane timing, in ns as built and in clock cycles of 10 ns
// ---------------------------------------------------------------
`define BSD_CLK_PERIOD_NS   10
`define BSD_ADDR_SETUP_NS   60
`define BSD_CMD_WIDTH_NS    250
`define BSD_ADDR_CYC \
    ((`BSD_ADDR_SETUP_NS + `BSD_CLK_PERIOD_NS - 1) / `BSD_CLK_PERIOD_NS)
`define BSD_CMD_CYC \
    ((`BSD_CMD_WIDTH_NS + `BSD_CLK_PERIOD_NS - 1) / `BSD_CLK_PERIOD_NS)

// ---------------------------------------------------------------
// Address decode
// ---------------------------------------------------------------
`define BSD_IO_ADDR_W       10
`define BSD_IO_EXPAND_QUAL_N_LO        10'h100
`define BSD_IO_EXPAND_QUAL_N_HI        10'h1ff

// ---------------------------------------------------------------
// Interrupt controllers: vector bases and fixed input positions
// ---------------------------------------------------------------
`define BSD_MASTER_BASE     5'h01
`define BSD_SLAVE_BASE      5'h0e
`define BSD_CASCADE_IN      3'h2
`define BSD_IRQ_VIDEO       9
`define BSD_IRQ_DISK        14

`endif

//--- common/bsd_pkg.sv
package bsd_pkg;

    typedef struct packed {
        logic        is_io;   // I/O cycle, else memory
        logic        wr;      // Write, else read
        logic        word;    // 16-bit access, else byte
        logic [23:0] addr;
        logic [15:0] wdata;
    } bsd_req_t;

    typedef struct packed {
        logic mem_rd_n;
        logic mem_wr_n;
        logic io_rd_n;
        logic io_wr_n;
        logic bhe_n;          // High byte lane enable
    } bsd_strb_t;

    typedef struct packed {
        logic timer;          // IRQ0
        logic kbd;            // IRQ1
        logic floppy;         // IRQ6
        logic rtc;            // IRQ8
        logic fpu;            // IRQ13
        logic spare;          // IRQ15
    } bsd_onb_irq_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_DONE
    } bsd_state_t;

endpackage

//--- hdl/bsd_io_decode.sv
`timescale 1ns/100ps
`include "bsd_regs.svh"

module bsd_io_decode #(
    parameter int AW = `BSD_IO_ADDR_W
) (
    input  wire logic [23:0]   cpu_addr,  // Address of pending cycle
    input  wire logic          is_io,     // Cycle is I/O
    input  wire logic          exp_en,    // Expansion option selected
    output logic      [23:0]   bp_addr,   // Address for backplane
    output logic               exp_hit    // Qualifier active
);
    logic [AW-1:0] io_addr;

    // Only 10 I/O address bits leave the board
    assign io_addr = cpu_addr[AW-1:0];
    assign bp_addr = is_io ? {{(24-AW){1'b0}}, io_addr} : cpu_addr;
    // Cards decoding 8 bits see 100-1ff via the qualifier
    assign exp_hit = is_io && exp_en
                  && io_addr >= `BSD_IO_EXPAND_QUAL_N_LO
                  && io_addr <= `BSD_IO_EXPAND_QUAL_N_HI;
endmodule

//--- hdl/bsd_pic_bank.sv
`timescale 1ns/100ps
`include "bsd_regs.svh"

module bsd_pic_bank (
    input  wire logic       clk,       // System clock
    input  wire logic       rst_n,     // Synchronised reset
    input  wire logic [7:0] irq,       // Requests, active high level
    input  wire logic [7:0] mask,      // 1 masks the input
    input  wire logic [4:0] vec_base,  // Vector bits 7:3
    input  wire logic       ack,       // Acknowledge pulse
    input  wire logic       eoi,       // End of interrupt pulse
    output logic            int_req,   // Request to next stage
    output logic [2:0]      sel,       // Input being requested
    output logic [7:0]      vector     // Vector of acknowledged input
);
    logic [7:0] isr_q;
    logic [7:0] isr_d;
    logic [7:0] vector_q;
    logic [7:0] pend;
    logic [2:0] isr_top;
    logic       isr_any;

    // Lowest index wins, as in the classic fixed priority scheme
    function automatic logic [2:0] prio(input logic [7:0] v);
        prio = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (v[i])
                prio = 3'(i);
    endfunction

    assign pend    = irq & ~mask;
    assign sel     = prio(pend);
    assign isr_top = prio(isr_q);
    assign isr_any = |isr_q;
    // Only a higher priority than the one in service may interrupt
    assign int_req = |pend && (!isr_any || sel < isr_top);
    assign isr_d   = (isr_q & ~((eoi && isr_any) ? (8'h01 << isr_top)
                                                 : 8'h00))
                   | (ack ? (8'h01 << sel) : 8'h00);
    assign vector  = vector_q;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            isr_q    <= 8'h00;
            vector_q <= 8'h00;
        end
        else
        begin
            isr_q <= isr_d;
            if (ack)
                vector_q <= {vec_base, sel};
        end
    end
endmodule

//--- tb/bsd_top_props.sv
`timescale 1ns/100ps
module bsd_top_props #(
    parameter int ADDR_CYC = 2,
    parameter int CMD_CYC  = 3
) (
    input wire logic               clk,              // Clock
    input wire logic               resetn,           // Reset, low
    input wire logic               cpu_inta,         // Int ack
    input wire logic               cpu_ready,        // Cycle done
    input wire logic               cpu_vec_valid,    // Vector valid
    input wire logic [23:0]        bp_addr,          // Address lines
    input wire logic               bp_addr_oe,       // Address drive
    input wire bsd_pkg::bsd_strb_t bp_strb,          // Strobes
    input wire logic               bp_data_oe,       // Data drive
    input wire logic               io_expand_en,     // Option
    input wire logic               io_expand_qual_n  // Qualifier
);
    logic       cmd_act;
    logic       io_act;
    logic [7:0] cmd_cnt_q;

    assign io_act = ~(bp_strb.io_rd_n & bp_strb.io_wr_n);
    assign cmd_act = io_act | ~(bp_strb.mem_rd_n & bp_strb.mem_wr_n);

    // Length of the current strobe pulse
    always_ff @(posedge clk or negedge resetn)
        if (!resetn)
            cmd_cnt_q <= 8'h00;
        else
            cmd_cnt_q <= cmd_act ? cmd_cnt_q + 8'h01 : 8'h00;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_ack;
        cpu_inta ##1 cpu_vec_valid;
    endsequence

    a_vec_follows_ack: assert property (cpu_inta |-> s_ack)
        else $error("vector not valid after acknowledge");
    a_vec_needs_ack: assert property
        (cpu_vec_valid |-> $past(cpu_inta))
        else $error("vector valid without acknowledge");
    a_ready_one_cycle: assert property (cpu_ready |=> !cpu_ready)
        else $error("ready longer than one cycle");
    a_strobe_width: assert property
        ($fell(cmd_act) |-> cmd_cnt_q == CMD_CYC)
        else $error("strobe width wrong");
    a_addr_setup: assert property
        ($rose(cmd_act) |-> $past(bp_addr_oe && !cmd_act, ADDR_CYC))
        else $error("address setup too short");
    a_addr_steady: assert property
        (cmd_act |-> bp_addr_oe && $stable(bp_addr))
        else $error("address moved under strobe");
    a_ready_ends_cmd: assert property
        (cpu_ready |-> !cmd_act && ($past(cmd_act) || $past(cmd_act, 2)))
        else $error("ready not at end of strobe");
    a_qual_in_range: assert property (!io_expand_qual_n |->
        io_expand_en && bp_addr_oe && bp_addr[9:8] == 2'h1)
        else $error("qualifier outside range");
    a_qual_when_due: assert property (io_act && io_expand_en &&
        bp_addr[9:8] == 2'h1 |-> !io_expand_qual_n)
        else $error("qualifier missing");
    a_io_ten_bits: assert property (io_act |-> bp_addr[23:10] == 14'h0)
        else $error("I/O address above ten bits");
    a_write_drive: assert property (bp_data_oe |->
        bp_addr_oe && bp_strb.mem_rd_n && bp_strb.io_rd_n)
        else $error("data driven outside write");
    // A request that coincides with an acknowledge is refused
    a_ack_no_cycle: assert property
        (cpu_inta && !bp_addr_oe |=> !bp_addr_oe)
        else $error("backplane cycle started by acknowledge");
endmodule

bind bsd_top bsd_top_props #(.ADDR_CYC(ADDR_CYC), .CMD_CYC(CMD_CYC))
    u_bsd_top_props (.clk, .resetn, .cpu_inta, .cpu_ready, .cpu_vec_valid,
    .bp_addr, .bp_addr_oe, .bp_strb, .bp_data_oe, .io_expand_en,
    .io_expand_qual_n);

//--- tb/bsd_card_model.sv
`timescale 1ns/100ps
module bsd_card_model (
    input wire logic               clk,            // Clock
    input wire logic [23:0]        bp_addr,        // Address lines
    input wire logic               bp_addr_oe,     // Address driven
    input wire bsd_pkg::bsd_strb_t bp_strb,        // Strobes
    input wire logic [15:0]        bp_data_out,    // Write data
    input wire logic               wide_mem,       // Memory card wide
    input wire logic               wide_io,        // I/O card wide
    output logic [15:0]            bp_data_in,     // Read data
    output logic                   mem_wide_ack_n, // Memory width ack
    output logic                   io_wide_ack_n   // I/O width ack
);
    logic [7:0]  mem [256];
    logic [15:0] last_q = 16'h0000;
    logic [7:0]  a;
    logic        rd;
    logic        wr;
    logic        wide;

    initial
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5a;

    assign a = bp_addr[7:0];
    assign rd = ~(bp_strb.mem_rd_n & bp_strb.io_rd_n);
    assign wr = ~(bp_strb.mem_wr_n & bp_strb.io_wr_n);
    assign wide = (bp_strb.io_rd_n & bp_strb.io_wr_n) ? wide_mem : wide_io;
    // Unselected, the lines sit at the pull-up level
    assign mem_wide_ack_n = ~(bp_addr_oe & wide_mem);
    assign io_wide_ack_n = ~(bp_addr_oe & wide_io);
    // Undriven lanes show the inverse of the last value
    assign bp_data_in = !rd ? ~last_q : wide ?
        {mem[a | 8'h01], mem[a & 8'hfe]} : {~last_q[15:8], mem[a]};

    always @(posedge clk)
    begin
        if (rd)
            last_q <= bp_data_in;
        if (wr && wide && !bp_strb.bhe_n)
            mem[a | 8'h01] <= bp_data_out[15:8];
        if (wr && (!wide || !a[0]))
            mem[a] <= bp_data_out[7:0];
    end
endmodule

//--- tb/bsd_top_tb_top.sv
`timescale 1ns/100ps
module bsd_top_tb_top;
    localparam int A = 2;
    localparam int C = 3;
    localparam int ORD [15] = '{0, 1, 8, 9, 10, 11, 12, 13, 14, 15,
                                3, 4, 5, 6, 7};
    logic clk = 0, resetn = 0, cpu_req = 0, cpu_inta = 0;
    logic cpu_eoi_m = 0, cpu_eoi_s = 0, io_expand_en = 0;
    logic wide_mem = 0, wide_io = 0, cmd_q = 0;
    logic [15:0] irq_mask = 0, src = 0, cpu_rdata, bp_data_in, bp_data_out;
    bsd_pkg::bsd_req_t cpu_cmd = '0;
    bsd_pkg::bsd_strb_t bp_strb;
    bsd_pkg::bsd_onb_irq_t onb_irq;
    logic cpu_ready, cpu_intr, cpu_vec_valid, bp_addr_oe, bp_data_oe;
    logic mem_wide_ack_n, io_wide_ack_n, io_expand_qual_n, cmd_now;
    logic bus_irq_a_n, bus_irq_b_n, bus_irq_c_n, fp_disk_irq_n, fp_video_irq_n;
    logic [3:0] fp_irq_n;
    logic [7:0] cpu_vector;
    logic [23:0] bp_addr;
    logic [7:0] m [256];
    int error_cnt = 0, checked = 0, cyc = 0, ph = 0, bhe_seen = 0, qual_seen = 0;

    assign bus_irq_a_n = ~src[10];
    assign bus_irq_b_n = ~src[11];
    assign bus_irq_c_n = ~src[12];
    assign fp_irq_n = ~{src[7], src[5], src[4], src[3]};
    assign fp_video_irq_n = ~src[9];
    assign fp_disk_irq_n = ~src[14];
    assign onb_irq = {src[0], src[1], src[6], src[8], src[13], src[15]};
    assign cmd_now = ~&{bp_strb.mem_rd_n, bp_strb.mem_wr_n,
                        bp_strb.io_rd_n, bp_strb.io_wr_n};

    bsd_top #(.ADDR_CYC(A), .CMD_CYC(C)) u_bsd_top (.clk, .resetn, .cpu_req,
        .cpu_cmd, .cpu_ready, .cpu_rdata, .cpu_inta, .cpu_eoi_m, .cpu_eoi_s,
        .cpu_intr, .cpu_vec_valid, .cpu_vector, .irq_mask, .io_expand_en,
        .bp_addr, .bp_addr_oe, .bp_strb, .bp_data_in, .bp_data_out,
        .bp_data_oe, .mem_wide_ack_n, .io_wide_ack_n, .io_expand_qual_n,
        .bus_irq_a_n, .bus_irq_b_n, .bus_irq_c_n, .fp_irq_n, .fp_disk_irq_n,
        .fp_video_irq_n, .onb_irq);
    bsd_card_model u_bsd_card_model (.clk, .bp_addr, .bp_addr_oe, .bp_strb,
        .bp_data_out, .wide_mem, .wide_io, .bp_data_in, .mem_wide_ack_n,
        .io_wide_ack_n);

    always #5 clk = ~clk;

    // Phase count, first-phase lane enable and qualifier per transfer
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            report_and_stop();
        end
        if (!cpu_req)
        begin
            ph = 0;
            bhe_seen = 0;
            qual_seen = 0;
        end
        else
        begin
            // Count strobe starts: an end would land on the ready edge
            if (!cmd_q && cmd_now)
                ph++;
            if (cmd_now && ph == 1 && !bp_strb.bhe_n)
                bhe_seen = 1;
            if (!io_expand_qual_n)
                qual_seen = 1;
        end
        cmd_q = cmd_now;
    end

    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task xfer(input logic io, wr, word, w, input logic [23:0] a,
              input logic [15:0] d);
        int k;
        logic [7:0] b;
        b = a[7:0];
        k = 0;
        wide_io <= io ? w : ~w;
        wide_mem <= io ? ~w : w;
        cpu_cmd <= '{io, wr, word, a, d};
        cpu_req <= 1;
        @(posedge clk);
        while (cpu_ready !== 1'b1 && k < 100)
        begin
            @(posedge clk);
            k++;
        end
        cpu_req <= 0;
        chk("phases", (word && !w) ? 16'h2 : 16'h1, 16'(ph));
        if (w || !a[0])
            chk("bhe", 16'(w && (word || a[0])), 16'(bhe_seen));
        chk("qual", 16'(io && io_expand_en && a[9:8] == 2'h1),
            16'(qual_seen));
        if (!wr)
            chk("rdata", word ? {m[b + 8'h1], m[b]} : {8'h0, m[b]},
                word ? cpu_rdata : {8'h0, cpu_rdata[7:0]});
        else
        begin
            m[b] = d[7:0];
            if (word)
                m[b + 8'h1] = d[15:8];
        end
        @(posedge clk);
    endtask

    task irq_case(input logic [15:0] s, msk, input int n);
        int k;
        k = 0;
        src <= s;
        irq_mask <= msk;
        @(posedge clk);
        while (cpu_intr !== 1'b1 && k < 8)
        begin
            @(posedge clk);
            k++;
        end
        chk("intr", 16'(n >= 0), {15'h0, cpu_intr});
        if (n >= 0)
        begin
            // A request raised with the acknowledge must not start a cycle
            cpu_inta <= 1;
            cpu_req <= 1;
            @(posedge clk);
            cpu_inta <= 0;
            cpu_req <= 0;
            @(posedge clk);
            chk("vector", 16'h0100 + (n < 8 ? 16'(8 + n)
                : 16'(8'h70 + n - 8)), {7'h0, cpu_vec_valid, cpu_vector});
            chk("ack bus", 16'h1f, {bp_addr_oe, bp_data_oe, bp_strb});
            cpu_eoi_m <= 1;
            cpu_eoi_s <= n >= 8;
        end
        src <= 0;
        @(posedge clk);
        cpu_eoi_m <= 0;
        cpu_eoi_s <= 0;
        repeat (8) @(posedge clk);
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        logic [31:0] r;
        logic [23:0] a;
        r = $urandom(30);
        for (int i = 0; i < 256; i++)
            m[i] = 8'(i) ^ 8'h5a;
        repeat (4) @(posedge clk);
        resetn <= 1;
        repeat (3) @(posedge clk);
        // Qualifier window edges, then random traffic
        io_expand_en <= 1;
        foreach (ORD[i])
            xfer(1, 0, 0, 1, {14'h0, 10'h0fe + 10'(i * 10'h40)}, 16'h0);
        for (int i = 0; i < 60; i++)
        begin
            r = $urandom;
            io_expand_en <= r[4];
            a = r[0] ? {14'h0, r[14:5]} : r[31:8];
            if (r[2])
                a[0] = 0;
            xfer(r[0], r[1], r[2], r[3], a, 16'($urandom));
        end
        $display("test transfers done");
        foreach (ORD[i])
        begin
            irq_case(16'h1 << ORD[i], 16'h0, ORD[i]);
            irq_case(16'h1 << ORD[i], 16'h1 << ORD[i], -1);
        end
        irq_case(16'h0400, 16'h0004, -1);
        irq_case(16'h0408, 16'h0000, 10);
        irq_case(16'h0088, 16'h0000, 3);
        $display("test interrupts done");
        report_and_stop();
    end
endmodule
